// ==== fifo_if_cfg.svh ====
`ifndef FIFO_IF_CFG_SVH
`define FIFO_IF_CFG_SVH
// register indices, same map on both ports
`define REG_DATA      4'h0
`define REG_COUNT     4'h1
`define REG_THRESH    4'h2
`define REG_CTRL      4'h3
`define REG_ISTS      4'h4
`define REG_IMASK     4'h5
`define REG_MSG_OUT   4'h6
`define REG_MSG_IN    4'h7
`define REG_VEC       4'h8
`define REG_MODE      4'h9
// control register bits
`define CTRL_DIR      0
`define CTRL_P2SEL_LO 1
`define CTRL_P2SEL_HI 2
`define CTRL_DMA_EN   3
`define CTRL_DMA_STRT 4
`define CTRL_DMA_GO   5
`define CTRL_GOUT_A   6
`define CTRL_GOUT_B   7
// interrupt status and mask bits
`define IRQ_MATCH     0
`define IRQ_OVF       1
`define IRQ_UNF       2
`define IRQ_EMPTY     3
`define IRQ_FULL      4
`define IRQ_MSG       5
`define IRQ_W         6
// port 2 protocol codes
`define P2_MUX        2'h0
`define P2_NONMUX     2'h1
`define P2_HS3        2'h2
`define P2_HS2        2'h3
// port 1 protocol codes from the select pins
`define P1_MUX_LO     2'h0
`define P1_MUX_HI     2'h1
`define P1_NONMUX     2'h2
`define RDATA_IDLE    8'h00
`endif

// ==== fifo_if_pkg.sv ====
package fifo_if_pkg;

  // one register access from a host
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bus_req_s;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WAIT = 2'b01,
    HS_REL  = 2'b10
  } hs_state_e;

  // per-port programmable state
  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] ctrl;
    logic [5:0] ists;
    logic [5:0] imask;
    logic [7:0] msg;
    logic [7:0] vec;
    logic [7:0] rdata;
    logic       match_q;
    logic       dma_run;
  } port_s;

endpackage : fifo_if_pkg

// ==== dual_port_fifo_interface.sv ====
// What this block does
// - shared 128x8 store, one write and one read may happen together
// - write and read pointers address store; fill count is their difference
// - each port reads the fill count from its own status register
// - threshold equal to count raises interrupt and starts or stops DMA
// - two message registers, one per direction, bypass the store
// - each port has sixteen register slots choosing protocol and pins
// - port 1 protocol from two pins, port 2 from port 1 control bits
// - twelve mode combinations decoded from pins and control bits
// - handshake protocols only on port 2, replacing bus control pins
// - empty, full and request/wait outputs pace transfers without polling
// - interrupts on match, overflow, underflow and buffer status changes
// - empty/full lines let devices stack in width and chain in depth
// - full status readable so blocks move by DMA, interrupt or polling
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_if_cfg.svh"

module dual_port_fifo_interface
  import fifo_if_pkg::*;
#(
  parameter int DEPTH = 128
)(
  input  wire logic     i_sys_clk,
  input  wire logic     i_sys_rst,
  input  wire bus_req_s i_p1_bus,
  input  wire bus_req_s i_p2_bus,
  output logic [7:0]    o_p1_rdata,
  output logic [7:0]    o_p2_rdata,
  input  wire logic     i_port1_select_pin_low,
  input  wire logic     i_port1_select_pin_high,
  input  wire logic     i_clear,
  input  wire logic     i_data_dir,
  input  wire logic     i_general_input_line,
  input  wire logic     i_handshake_acknowledge_in,
  input  wire logic     i_handshake_valid_or_accepted,
  input  wire logic     i_handshake_accepted_or_ready,
  input  wire logic [7:0] i_hs_data,
  output logic [7:0]    o_hs_data,
  output logic          o_handshake_ready_or_valid,
  output logic          o_empty,
  output logic          o_full,
  output logic [1:0]    o_request_or_wait_out,
  output logic [1:0]    o_irq,
  output logic          o_general_output_line_a,
  output logic          o_general_output_line_b
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    port_s [1:0] p;
    logic [AW:0] wp;
    logic [AW:0] rp;
    hs_state_e   hs;
    logic [7:0]  hs_dout;
    logic        empty_q;
    logic        full_q;
  } state_s;

  state_s          r;
  state_s          r_nxt;
  logic [7:0]      mem [DEPTH];           // storage, no reset needed
  bus_req_s [1:0]  bus;
  logic [AW:0]     count;
  logic [AW:0]     count_nxt;
  logic            empty;
  logic            full;
  logic [1:0]      p2mode;
  logic [1:0]      p1mode;
  logic            hs_mode;
  logic            hs_three;
  logic            wrp;
  logic            rdp;
  logic            hs_ack;
  logic            hs_push;
  logic            hs_pop;
  logic            push_req;
  logic            pop_req;
  logic            push;
  logic            pop;
  logic [7:0]      push_data;
  logic [1:0][5:0] ev;
  logic [1:0]      match;

  assign bus = {i_p2_bus, i_p1_bus};

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and fill count
  assign count    = r.wp - r.rp;
  assign empty    = (count == '0);
  assign full     = (count == (AW+1)'(DEPTH));
  assign p1mode   = {i_port1_select_pin_high, i_port1_select_pin_low};
  assign p2mode   = r.p[0].ctrl[`CTRL_P2SEL_HI:`CTRL_P2SEL_LO];
  assign hs_mode  = (p2mode == `P2_HS3) || (p2mode == `P2_HS2);
  assign hs_three = (p2mode == `P2_HS3);
  // in handshake mode the direction pin replaces the control bit
  assign wrp      = hs_mode ? i_data_dir : r.p[0].ctrl[`CTRL_DIR];
  assign rdp      = ~wrp;
  assign hs_ack   = hs_three ? i_handshake_valid_or_accepted
                             : i_handshake_acknowledge_in;

  ////////////////////////////////////////////////////////////////////////////
  // push and pop; a refused access leaves the pointers alone
  always_comb
  begin
    push_req  = (hs_mode && wrp) ? hs_push
                                 : (bus[wrp].wr && bus[wrp].addr == `REG_DATA);
    pop_req   = (hs_mode && rdp) ? hs_pop
                                 : (bus[rdp].rd && bus[rdp].addr == `REG_DATA);
    push      = push_req && !full;
    pop       = pop_req && !empty;
    push_data = (hs_mode && wrp) ? i_hs_data : bus[wrp].wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // whole next state
  always_comb
  begin
    logic [5:0] pend;
    logic [2:0] code;
    pend    = '0;
    code    = '0;
    r_nxt   = r;
    hs_push = 1'b0;
    hs_pop  = 1'b0;
    // interlocked handshake on port 2, data either way
    case (r.hs)
      HS_IDLE:
      begin
        if (hs_mode && rdp)
        begin
          // three-wire waits for the listener to be ready first
          if (!empty && (!hs_three || i_handshake_accepted_or_ready))
          begin
            hs_pop    = 1'b1;
            r_nxt.hs_dout = mem[r.rp[AW-1:0]];
            r_nxt.hs  = HS_WAIT;
          end
        end
        else if (hs_mode && hs_ack && !full)
        begin
          hs_push  = 1'b1;
          r_nxt.hs = HS_REL;
        end
      end
      HS_WAIT:
      begin
        if (!hs_mode || hs_ack)
          r_nxt.hs = hs_mode ? HS_REL : HS_IDLE;
      end
      HS_REL:
      begin
        if (!hs_mode || !hs_ack)
          r_nxt.hs = HS_IDLE;
      end
      default:
        r_nxt.hs = HS_IDLE;
    endcase
    // pointers move independently, so both may step together
    if (push)
      r_nxt.wp = r.wp + 1'b1;
    if (pop)
      r_nxt.rp = r.rp + 1'b1;
    if (hs_mode && i_clear)
    begin
      r_nxt.wp = '0;
      r_nxt.rp = '0;
      r_nxt.hs = HS_IDLE;
    end
    count_nxt     = r_nxt.wp - r_nxt.rp;
    r_nxt.empty_q = (count_nxt == '0);
    r_nxt.full_q  = (count_nxt == (AW+1)'(DEPTH));
    // per-port registers and events
    for (int k = 0; k < 2; k++)
    begin
      match[k] = (8'(count) == r.p[k].thresh);
      ev[k] = '0;
      ev[k][`IRQ_MATCH] = match[k] && !r.p[k].match_q;
      ev[k][`IRQ_OVF]   = (1'(k) == wrp) && push_req && full;
      ev[k][`IRQ_UNF]   = (1'(k) == rdp) && pop_req && empty;
      ev[k][`IRQ_EMPTY] = r_nxt.empty_q != r.empty_q;
      ev[k][`IRQ_FULL]  = r_nxt.full_q != r.full_q;
      ev[k][`IRQ_MSG]   = bus[1-k].wr && bus[1-k].addr == `REG_MSG_OUT;
      r_nxt.p[k].match_q = match[k];
      // set wins over a write-one clear in the same cycle
      r_nxt.p[k].ists = r.p[k].ists | ev[k];
      if (bus[k].wr)
      begin
        case (bus[k].addr)
          `REG_THRESH:  r_nxt.p[k].thresh = bus[k].wdata;
          `REG_CTRL:
          begin
            r_nxt.p[k].ctrl    = bus[k].wdata;
            r_nxt.p[k].dma_run = bus[k].wdata[`CTRL_DMA_GO];
          end
          `REG_ISTS:
            r_nxt.p[k].ists = (r.p[k].ists & ~bus[k].wdata[5:0]) | ev[k];
          `REG_IMASK:   r_nxt.p[k].imask = bus[k].wdata[5:0];
          `REG_MSG_OUT: r_nxt.p[k].msg = bus[k].wdata;
          `REG_VEC:     r_nxt.p[k].vec = bus[k].wdata;
          default:      r_nxt.p[k] = r_nxt.p[k];
        endcase
      end
      // threshold starts or stops dma as the control bits ask
      if (ev[k][`IRQ_MATCH] && r.p[k].ctrl[`CTRL_DMA_EN])
        r_nxt.p[k].dma_run = r.p[k].ctrl[`CTRL_DMA_STRT];
      pend = r.p[k].ists & r.p[k].imask;
      code = '0;
      for (int j = `IRQ_W - 1; j >= 0; j--)
        if (pend[j])
          code = 3'(j);
      r_nxt.p[k].rdata = `RDATA_IDLE;
      if (bus[k].rd)
      begin
        case (bus[k].addr)
          `REG_DATA:
            r_nxt.p[k].rdata = (1'(k) == rdp && pop && !(hs_mode && k == 1))
                               ? mem[r.rp[AW-1:0]] : `RDATA_IDLE;
          `REG_COUNT:   r_nxt.p[k].rdata = 8'(count);
          `REG_THRESH:  r_nxt.p[k].rdata = r.p[k].thresh;
          `REG_CTRL:    r_nxt.p[k].rdata = r.p[k].ctrl;
          `REG_ISTS:    r_nxt.p[k].rdata = {2'b00, r.p[k].ists};
          `REG_IMASK:   r_nxt.p[k].rdata = {2'b00, r.p[k].imask};
          `REG_MSG_OUT: r_nxt.p[k].rdata = r.p[k].msg;
          `REG_MSG_IN:  r_nxt.p[k].rdata = r.p[1-k].msg;
          `REG_VEC:     r_nxt.p[k].rdata = {r.p[k].vec[7:3], code};
          `REG_MODE:
            r_nxt.p[k].rdata = {i_general_input_line, r.full_q, r.empty_q,
                                r.p[k].dma_run, 2'b00,
                                (k == 0) ? p1mode : p2mode};
          default:      r_nxt.p[k].rdata = `RDATA_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      r         <= '0;
      r.empty_q <= 1'b1;
    end
    else
      r <= r_nxt;
  end

  // storage write port; read side uses the other pointer
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
      mem[r.wp[AW-1:0]] <= push_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      // writer asks while room, reader while data; dma gates both
      o_request_or_wait_out[k] =
        ((1'(k) == wrp) ? !r.full_q : !r.empty_q) &&
        (!r.p[k].ctrl[`CTRL_DMA_EN] || r.p[k].dma_run);
      o_irq[k] = |(r.p[k].ists & r.p[k].imask);
    end
  end
  assign o_p1_rdata = r.p[0].rdata;
  assign o_p2_rdata = r.p[1].rdata;
  assign o_hs_data  = r.hs_dout;
  assign o_empty    = r.empty_q;
  assign o_full     = r.full_q;
  assign o_general_output_line_a = r.p[1].ctrl[`CTRL_GOUT_A];
  assign o_general_output_line_b = r.p[1].ctrl[`CTRL_GOUT_B];
  assign o_handshake_ready_or_valid = hs_mode &&
    (rdp ? (r.hs == HS_WAIT) : (r.hs == HS_IDLE && !r.full_q));

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  property p_count_step;
    push && !pop && !(hs_mode && i_clear) |=> count == $past(count) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step on push");

  property p_ovf;
    push_req && full && !pop && !(hs_mode && i_clear)
      |=> $stable(r.wp) && r.p[wrp].ists[`IRQ_OVF];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow moved pointer or missed flag");

  property p_unf;
    pop_req && empty && !(hs_mode && i_clear)
      |=> $stable(r.rp) && r.p[rdp].ists[`IRQ_UNF];
  endproperty
  a_unf: assert property (p_unf)
    else $error("underflow moved pointer or missed flag");

  property p_count_read;
    i_p2_bus.rd && i_p2_bus.addr == `REG_COUNT
      |=> o_p2_rdata == 8'($past(count));
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count register read wrong");

  property p_match_irq;
    match[0] && !r.p[0].match_q && r.p[0].imask[`IRQ_MATCH] &&
      !(i_p1_bus.wr && i_p1_bus.addr == `REG_IMASK) |=> o_irq[0];
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("threshold match gave no interrupt");

  property p_msg;
    i_p1_bus.wr && i_p1_bus.addr == `REG_MSG_OUT ##1
      i_p2_bus.rd && i_p2_bus.addr == `REG_MSG_IN
      |=> o_p2_rdata == $past(i_p1_bus.wdata, 2);
  endproperty
  a_msg: assert property (p_msg)
    else $error("message not passed across");

  property p_full_wait;
    o_full && !wrp |-> !o_request_or_wait_out[0];
  endproperty
  a_full_wait: assert property (p_full_wait)
    else $error("request while full");

  property p_bus_no_hs;
    !hs_mode |-> !o_handshake_ready_or_valid;
  endproperty
  a_bus_no_hs: assert property (p_bus_no_hs)
    else $error("handshake line active in bus mode");

  property p_set_wins;
    ev[0][`IRQ_OVF] |=> r.p[0].ists[`IRQ_OVF];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against clear");

  c_fill: cover property (o_full);
  c_both: cover property (push && pop);
  c_hs:   cover property (r.hs == HS_WAIT ##[1:20] r.hs == HS_IDLE);
  c_irq:  cover property (o_irq[1]);

endmodule : dual_port_fifo_interface
`default_nettype wire

// ==== fifo_hs_peer.sv ====
`timescale 1ns/1ns
`default_nettype none

// handshake listener on the far side of port 2 (output direction)
module fifo_hs_peer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_valid,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_three_wire,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack_two,
  output logic             o_ack_three,
  output logic             o_ready,
  output logic [23:0]      o_seen,
  output logic [7:0]       o_got
);
  logic       ack_r;
  logic [3:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // accept after a programmable stall, drop ack once valid has fallen
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_r  <= 1'b0;
      wait_r <= 4'h0;
      o_seen <= 24'h000000;
      o_got  <= 8'h00;
    end
    else if (!ack_r && i_valid)
    begin
      if (wait_r == i_delay)
      begin
        ack_r  <= 1'b1;
        wait_r <= 4'h0;
        o_seen <= {o_seen[15:0], i_data};
        o_got  <= o_got + 8'h01;
      end
      else
        wait_r <= wait_r + 4'h1;
    end
    else if (ack_r && !i_valid)
      ack_r <= 1'b0;
  end

  // only the wire of the chosen protocol moves; ready low while acking
  assign o_ack_two   = !i_three_wire && ack_r;
  assign o_ack_three = i_three_wire && ack_r;
  assign o_ready     = !ack_r;
endmodule : fifo_hs_peer

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fifo_if_cfg.svh"

module tb
  import fifo_if_pkg::*;
;
  localparam int DEPTH = 8; // short store keeps the full case cheap
  logic        clk, rst, sel_lo, sel_hi, gin, ack2, ack3, rdy, hval;
  logic        emp, ful, oa, ob, three, dir, clr_in;
  bus_req_s    p1, p2;
  logic [7:0]  r1, r2, hsd, got, hsin;
  logic [1:0]  rw, irq;
  logic [3:0]  dly;
  logic [23:0] seen;
  int          checks, miscompares;

  // talker bytes follow the peer's strobe count, so each push differs
  assign hsin = got ^ 8'hB0;

  dual_port_fifo_interface #(.DEPTH(DEPTH)) DUT (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_p1_bus(p1), .i_p2_bus(p2),
    .o_p1_rdata(r1), .o_p2_rdata(r2), .i_port1_select_pin_low(sel_lo),
    .i_port1_select_pin_high(sel_hi), .i_clear(clr_in), .i_data_dir(dir),
    .i_general_input_line(gin), .i_handshake_acknowledge_in(ack2),
    .i_handshake_valid_or_accepted(ack3),
    .i_handshake_accepted_or_ready(rdy), .i_hs_data(hsin),
    .o_hs_data(hsd), .o_handshake_ready_or_valid(hval), .o_empty(emp),
    .o_full(ful), .o_request_or_wait_out(rw), .o_irq(irq),
    .o_general_output_line_a(oa), .o_general_output_line_b(ob));

  fifo_hs_peer PEER (
    .i_clk(clk), .i_rst(rst), .i_valid(hval), .i_data(hsd),
    .i_three_wire(three), .i_delay(dly), .o_ack_two(ack2),
    .o_ack_three(ack3), .o_ready(rdy), .o_seen(seen), .o_got(got));

  ////////////////////////////////////////////////////////////////////////////
  // shared bus and compare helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one-cycle strobe, then idle; no second access in the same edge
  task automatic acc(input bit ps, input logic r, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    if (ps) p2 <= '{rd: r, wr: !r, addr: a, wdata: d};
    else p1 <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk);
    p1 <= '0;
    p2 <= '0;
  endtask : acc

  task automatic wr(input bit ps, input logic [3:0] a, input logic [7:0] d);
    acc(ps, 1'b0, a, d);
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input bit ps, input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    acc(ps, 1'b1, a, 8'h00);
    @(negedge clk);
    chk((ps ? r2 : r1) & m, e);
  endtask : rdc

  task automatic clr;
    wr(0, `REG_ISTS, 8'hFF);
    wr(1, `REG_ISTS, 8'hFF);
  endtask : clr

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    chk({6'h00, ful, emp}, 8'h01);
    chk({6'h00, irq}, 8'h00);
    rdc(1, `REG_COUNT, 8'hFF, 8'h00);
    wr(0, 4'hC, 8'h77);
    rdc(0, 4'hC, 8'hFF, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_order;
    wr(0, `REG_THRESH, 8'hFF);
    for (int i = 0; i < 3; i++)
      wr(0, `REG_DATA, 8'hA0 + 8'(i));
    rdc(0, `REG_COUNT, 8'hFF, 8'h03);
    rdc(1, `REG_COUNT, 8'hFF, 8'h03);
    // write and read in the same cycle must not disturb each other
    @(posedge clk);
    p1 <= '{rd: 1'b0, wr: 1'b1, addr: `REG_DATA, wdata: 8'hA3};
    p2 <= '{rd: 1'b1, wr: 1'b0, addr: `REG_DATA, wdata: 8'h00};
    @(posedge clk);
    p1 <= '0;
    p2 <= '0;
    @(negedge clk);
    chk(r2, 8'hA0);
    for (int i = 1; i < 4; i++)
      rdc(1, `REG_DATA, 8'hFF, 8'hA0 + 8'(i));
    rdc(0, `REG_COUNT, 8'hFF, 8'h00);
    clr;
    $display("test order done");
  endtask : t_order

  task automatic t_thresh;
    wr(0, `REG_VEC, 8'hA8);
    wr(0, `REG_IMASK, 8'h01);
    wr(0, `REG_THRESH, 8'h02);
    wr(0, `REG_DATA, 8'h31);
    @(negedge clk);
    chk({6'h00, irq}, 8'h00);
    wr(0, `REG_DATA, 8'h32);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({6'h00, irq}, 8'h01);
    rdc(0, `REG_VEC, 8'hFF, 8'hA8);
    wr(0, `REG_ISTS, 8'h01);
    @(negedge clk);
    chk({6'h00, irq}, 8'h00);
    rdc(1, `REG_DATA, 8'hFF, 8'h31);
    rdc(1, `REG_DATA, 8'hFF, 8'h32);
    wr(0, `REG_IMASK, 8'h00);
    wr(0, `REG_THRESH, 8'hFF);
    clr;
    $display("test threshold done");
  endtask : t_thresh

  task automatic t_full;
    for (int i = 0; i < DEPTH; i++)
      wr(0, `REG_DATA, 8'h10 + 8'(i));
    @(negedge clk);
    chk({4'h0, ful, emp, rw}, 8'h0A);
    wr(0, `REG_DATA, 8'hEE);
    rdc(0, `REG_COUNT, 8'hFF, 8'(DEPTH));
    rdc(0, `REG_ISTS, 8'h02, 8'h02);
    for (int i = 0; i < DEPTH; i++)
      rdc(1, `REG_DATA, 8'hFF, 8'h10 + 8'(i));
    rdc(1, `REG_DATA, 8'hFF, 8'h00);
    rdc(1, `REG_ISTS, 8'h04, 8'h04);
    rdc(1, `REG_COUNT, 8'hFF, 8'h00);
    chk({4'h0, ful, emp, rw}, 8'h05);
    clr;
    $display("test full and empty done");
  endtask : t_full

  // threshold match on the reader port starts, then stops, its dma request
  task automatic t_dma;
    wr(1, `REG_THRESH, 8'h02);
    wr(1, `REG_CTRL, 8'h18);
    wr(0, `REG_DATA, 8'h41);
    @(negedge clk);
    chk({6'h00, rw}, 8'h01);
    wr(0, `REG_DATA, 8'h42);
    @(posedge clk);
    @(negedge clk);
    chk({6'h00, rw}, 8'h03);
    wr(1, `REG_THRESH, 8'h01);
    wr(1, `REG_CTRL, 8'h28);
    rdc(1, `REG_DATA, 8'hFF, 8'h41);
    @(negedge clk);
    chk({6'h00, rw}, 8'h01);
    rdc(1, `REG_DATA, 8'hFF, 8'h42);
    wr(1, `REG_CTRL, 8'h00);
    clr;
    $display("test dma done");
  endtask : t_dma

  task automatic t_msg;
    wr(0, `REG_MSG_OUT, 8'h5A);
    rdc(1, `REG_MSG_IN, 8'hFF, 8'h5A);
    rdc(1, `REG_ISTS, 8'h20, 8'h20);
    wr(1, `REG_IMASK, 8'h20);
    @(negedge clk);
    chk({6'h00, irq}, 8'h02);
    wr(1, `REG_IMASK, 8'h00);
    rdc(0, `REG_MSG_OUT, 8'hFF, 8'h5A);
    wr(1, `REG_MSG_OUT, 8'hC3);
    rdc(0, `REG_MSG_IN, 8'hFF, 8'hC3);
    rdc(0, `REG_COUNT, 8'hFF, 8'h00);
    // write then read across with no idle cycle between the strobes
    @(posedge clk);
    p1 <= '{rd: 1'b0, wr: 1'b1, addr: `REG_MSG_OUT, wdata: 8'h96};
    @(posedge clk);
    p1 <= '0;
    p2 <= '{rd: 1'b1, wr: 1'b0, addr: `REG_MSG_IN, wdata: 8'h00};
    @(posedge clk);
    p2 <= '0;
    @(negedge clk);
    chk(r2, 8'h96);
    clr;
    $display("test message done");
  endtask : t_msg

  // all twelve pin and field combinations
  task automatic t_mode;
    for (int pc = 0; pc < 3; pc++)
      for (int f = 0; f < 4; f++)
      begin
        @(posedge clk);
        {sel_hi, sel_lo} <= 2'(pc);
        gin <= pc[0];
        wr(0, `REG_CTRL, {5'h00, 2'(f), 1'b0});
        rdc(0, `REG_MODE, 8'hFF, {pc[0], 5'b01000, 2'(pc)});
        rdc(1, `REG_MODE, 8'hFF, {pc[0], 5'b01000, 2'(f)});
      end
    wr(0, `REG_CTRL, 8'h00);
    wr(1, `REG_CTRL, 8'hC0);
    @(negedge clk);
    chk({6'h00, ob, oa}, 8'h03);
    wr(1, `REG_CTRL, 8'h00);
    $display("test modes done");
  endtask : t_mode

  // 2-wire then 3-wire draining by the peer, the second one stalling
  task automatic t_hs;
    logic [7:0] g0;
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      three <= m[0];
      dly <= m[0] ? 4'h3 : 4'h0;
      g0 = got;
      wr(0, `REG_CTRL, m[0] ? 8'h04 : 8'h06);
      for (int i = 0; i < 3; i++)
        wr(0, `REG_DATA, 8'h60 + 8'(16 * m + i));
      for (int n = 0; n < 200 && got !== g0 + 8'h03; n++)
        @(posedge clk);
      @(negedge clk);
      chk(got - g0, 8'h03);
      for (int k = 0; k < 3; k++)
        chk(seen[8 * (2 - k) +: 8], 8'h60 + 8'(16 * m + k));
      chk({7'h00, emp}, 8'h01);
    end
    wr(0, `REG_CTRL, 8'h00);
    @(negedge clk);
    chk({7'h00, hval}, 8'h00);
    clr;
    $display("test handshake done");
  endtask : t_hs

  // port 2 as listener: the peer strobes while ready until full, then clear
  task automatic t_hsin;
    logic [7:0] g0;
    @(posedge clk);
    dir <= 1'b1;
    three <= 1'b0;
    dly <= 4'h0;
    g0 = got;
    wr(0, `REG_CTRL, 8'h06);
    repeat (60) @(posedge clk);
    @(negedge clk);
    chk({6'h00, ful, hval}, 8'h02);
    rdc(0, `REG_COUNT, 8'hFF, 8'(DEPTH));
    rdc(0, `REG_DATA, 8'hFF, 8'hB0 ^ (g0 + 8'h01));
    @(posedge clk);
    clr_in <= 1'b1;
    @(posedge clk);
    clr_in <= 1'b0;
    @(negedge clk);
    chk({7'h00, emp}, 8'h01);
    wr(0, `REG_CTRL, 8'h00);
    @(posedge clk);
    dir <= 1'b0;
    $display("test handshake input done");
  endtask : t_hsin

  ////////////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test;
  end

  initial
  begin
    rst = 1'b1;
    p1 = '0;
    p2 = '0;
    {sel_hi, sel_lo, gin, three, dir, clr_in} = 6'h00;
    dly = 4'h0;
    checks = 0;
    miscompares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_order;
    t_thresh;
    t_full;
    t_dma;
    t_msg;
    t_mode;
    t_hs;
    t_hsin;
    end_of_test;
  end
endmodule : tb

`default_nettype wire
